// >>> rtl/hsu_map.vh
// Register map, field positions, reset values and timing for the host serial port.
// Assumes an 8-bit special-function register port with a byte address.
`ifndef HSU_MAP_VH
`define HSU_MAP_VH

`define HSU_ADDR_STA 8'hAB
`define HSU_ADDR_CTR 8'hAC
`define HSU_ADDR_PRE 8'hAD
`define HSU_ADDR_CNT 8'hAE
`define HSU_ADDR_FIFO_DATA_PORT 8'hA2

`define SERIAL_STATUS_FLAGS_FER 0
`define SERIAL_STATUS_FLAGS_OVR 1
`define SERIAL_STATUS_FLAGS_FER_EN 2
`define SERIAL_STATUS_FLAGS_OVR_EN 3
`define SERIAL_STATUS_FLAGS_NOPRE 4
`define SERIAL_STATUS_FLAGS_SETBIT 7
`define SERIAL_STATUS_FLAGS_RW_MASK 8'h1F

`define SERIAL_CONTROL_GATE_N 0
`define SERIAL_CONTROL_RX_EN 1
`define SERIAL_CONTROL_TX_EN 2
`define SERIAL_CONTROL_RX_STOP 3
`define SERIAL_CONTROL_TX_STOP_LO 4
`define SERIAL_CONTROL_TX_STOP_HI 5
`define SERIAL_CONTROL_REARM 6
`define SERIAL_CONTROL_WAKE_ARM 7

`define SERIAL_STATUS_FLAGS_RESET 8'h00
`define SERIAL_CONTROL_RESET 8'h01
`define HSU_PRE_RESET 8'h18
`define BAUD_DIVIDER_COUNT_RESET 8'h10

`define HSU_WAKE_COUNT 3'h5
`define HSU_FIFO_WIDTH 8
`define HSU_FIFO_DEPTH 32
`define HSU_FIFO_AW 5
`define HSU_CLK_KHZ 125000
`define HSU_REF_KHZ 27120
`define HSU_MAX_KBPS 1288

`endif

// >>> rtl/hsu_fifo.v
// Flip-flop FIFO with valid and ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module hsu_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 32,
   parameter AW = 5
)
(
   input wire i_clk,
   input wire i_nrst,
   input wire i_flush,
   input wire [WIDTH-1:0] i_in_data,
   input wire i_in_valid,
   output wire o_in_ready,
   output wire [WIDTH-1:0] o_out_data,
   output wire o_out_valid,
   input wire i_out_ready
);
   reg [WIDTH-1:0] mem_r [0:DEPTH-1];
   reg [AW-1:0] wr_r;
   reg [AW-1:0] rd_r;
   reg [AW:0] cnt_r;
   wire push;
   wire pop;

   assign o_in_ready = (cnt_r != DEPTH[AW:0]);
   assign o_out_valid = (cnt_r != {(AW+1){1'b0}});
   assign o_out_data = mem_r[rd_r];
   assign push = i_in_valid & o_in_ready;
   assign pop = o_out_valid & i_out_ready;

   always @(posedge i_clk)
   begin
      if (push)
      begin
         mem_r[wr_r] <= i_in_data;
      end
   end

   always @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         wr_r <= {AW{1'b0}};
         rd_r <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
      end
      else if (i_flush)
      begin
         wr_r <= {AW{1'b0}};
         rd_r <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
         begin
            wr_r <= (wr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_r + 1'b1;
         end
         if (pop)
         begin
            rd_r <= (rd_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_r + 1'b1;
         end
         if (push & ~pop)
         begin
            cnt_r <= cnt_r + 1'b1;
         end
         else if (pop & ~push)
         begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule

// >>> rtl/hsu_uart.v
// Host serial port: registers, baud generator, transmitter, receiver with
// holding FIFO, preamble filter, wake counter and error flags.
// Assumes an 8-bit register port synchronous to i_clk, a FIFO manager with
// valid/accept handshakes, and serial input already synchronous to i_clk.
`timescale 1ns/1ps
`include "hsu_map.vh"
module hsu_uart
(
   input wire i_clk,
   input wire i_nrst,
   input wire [7:0] i_addr,
   input wire i_wr,
   input wire i_rd,
   input wire [7:0] i_wdata,
   output reg [7:0] o_rdata,
   input wire i_cpu_irq_gate,
   input wire i_rx,
   output reg o_tx,
   output reg o_fifo_valid,
   output reg [7:0] o_fifo_data,
   input wire i_fifo_accept,
   output reg o_wake_request,
   output reg o_irq
);
   localparam TX_IDLE = 4'b0001;
   localparam TX_START = 4'b0010;
   localparam TX_DATA = 4'b0100;
   localparam TX_STOP = 4'b1000;
   localparam RX_IDLE = 4'b0001;
   localparam RX_START = 4'b0010;
   localparam RX_DATA = 4'b0100;
   localparam RX_STOP = 4'b1000;
   // Reference rate increment per system clock, fixed-point 16 bits
   localparam integer REF_STEP_I = (`HSU_REF_KHZ * 65536) / `HSU_CLK_KHZ;
   localparam [16:0] REF_STEP = REF_STEP_I[16:0];

   reg [7:0] sta_r;
   reg [7:0] ctr_r;
   reg [7:0] pre_r;
   reg [7:0] cnt_r;
   reg [7:0] txbuf_r;
   reg txbuf_full_r;
   reg [16:0] ref_acc_r;
   reg [7:0] pre_cnt_r;
   reg [3:0] tx_state_r;
   reg [7:0] tx_baud_r;
   reg [7:0] tx_sh_r;
   reg [2:0] tx_bit_r;
   reg [1:0] tx_stop_r;
   reg [3:0] rx_state_r;
   reg [7:0] rx_baud_r;
   reg [7:0] rx_sh_r;
   reg [2:0] rx_bit_r;
   reg rx_stop_r;
   reg rx_prev_r;
   reg [2:0] wake_cnt_r;
   reg filt_armed_r;
   reg [1:0] filt_seen_r;
   reg rx_push_r;
   reg [7:0] rx_byte_r;

   wire gate_on = ctr_r[`SERIAL_CONTROL_GATE_N];
   wire ref_tick = ref_acc_r[16];
   wire sta_sel = i_addr == `HSU_ADDR_STA;
   wire ctr_sel = i_addr == `HSU_ADDR_CTR;
   wire data_wr = i_wr & (i_addr == `HSU_ADDR_FIFO_DATA_PORT);
   wire [7:0] pre_mask;
   wire baud_tick;
   wire fifo_in_ready;
   wire [7:0] fifo_out_data;
   wire fifo_out_valid;
   wire rx_done;
   wire rx_fer;
   wire pass_byte;
   wire fifo_pop;
   reg [7:0] sta_nxt;

   // Prescaler exponent 0..8 from the low nibble; larger values clamp to 256
   function [7:0] pre_mask_of;
      input [7:0] p;
      begin
         pre_mask_of = (p[3:0] >= 4'h8) ? 8'hFF : ((8'h01 << p[3:0]) - 8'h01);
      end
   endfunction

   assign pre_mask = pre_mask_of(pre_r);
   assign baud_tick = gate_on & ref_tick & ((pre_cnt_r & pre_mask) == 8'h00);

   // Reference clock emulation by phase accumulator
   always @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         ref_acc_r <= 17'h00000;
         pre_cnt_r <= 8'h00;
      end
      else if (!gate_on)
      begin
         ref_acc_r <= 17'h00000;
         pre_cnt_r <= 8'h00;
      end
      else
      begin
         ref_acc_r <= {1'b0, ref_acc_r[15:0]} + REF_STEP;
         if (ref_tick)
         begin
            pre_cnt_r <= pre_cnt_r + 8'h01;
         end
      end
   end

   // Register port
   always @*
   begin
      sta_nxt = sta_r;
      if (i_wr & sta_sel)
      begin
         if (i_wdata[`SERIAL_STATUS_FLAGS_SETBIT])
         begin
            sta_nxt = sta_r | (i_wdata & `SERIAL_STATUS_FLAGS_RW_MASK);
         end
         else
         begin
            sta_nxt = sta_r & ~(i_wdata & `SERIAL_STATUS_FLAGS_RW_MASK);
         end
      end
      // Hardware set wins over a clear in the same cycle
      if (rx_done & rx_fer)
      begin
         sta_nxt[`SERIAL_STATUS_FLAGS_FER] = 1'b1;
      end
      if (rx_done & ~rx_fer & pass_byte & ~fifo_in_ready)
      begin
         sta_nxt[`SERIAL_STATUS_FLAGS_OVR] = 1'b1;
      end
   end

   always @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         sta_r <= `SERIAL_STATUS_FLAGS_RESET;
         ctr_r <= `SERIAL_CONTROL_RESET;
         pre_r <= `HSU_PRE_RESET;
         cnt_r <= `BAUD_DIVIDER_COUNT_RESET;
         o_rdata <= 8'h00;
         o_irq <= 1'b0;
      end
      else
      begin
         sta_r <= sta_nxt;
         if (i_wr & ctr_sel)
         begin
            ctr_r <= {2'b00, i_wdata[5:0]};
         end
         if (i_wr & (i_addr == `HSU_ADDR_PRE))
         begin
            pre_r <= i_wdata;
         end
         if (i_wr & (i_addr == `HSU_ADDR_CNT))
         begin
            cnt_r <= i_wdata;
         end
         if (i_rd)
         begin
            case (i_addr)
               `HSU_ADDR_STA: o_rdata <= sta_r;
               `HSU_ADDR_CTR: o_rdata <= ctr_r;
               `HSU_ADDR_PRE: o_rdata <= pre_r;
               `HSU_ADDR_CNT: o_rdata <= cnt_r;
               `HSU_ADDR_FIFO_DATA_PORT: o_rdata <= rx_byte_r;
               default: o_rdata <= 8'h00;
            endcase
         end
         o_irq <= i_cpu_irq_gate & ((sta_r[`SERIAL_STATUS_FLAGS_OVR] & sta_r[`SERIAL_STATUS_FLAGS_OVR_EN]) |
                  (sta_r[`SERIAL_STATUS_FLAGS_FER] & sta_r[`SERIAL_STATUS_FLAGS_FER_EN]));
      end
   end

   // Transmitter; one-byte holding register fed by the data port
   always @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         txbuf_r <= 8'h00;
         txbuf_full_r <= 1'b0;
         tx_state_r <= TX_IDLE;
         tx_baud_r <= 8'h00;
         tx_sh_r <= 8'h00;
         tx_bit_r <= 3'h0;
         tx_stop_r <= 2'h0;
         o_tx <= 1'b1;
      end
      else
      begin
         if (data_wr)
         begin
            txbuf_r <= i_wdata;
            txbuf_full_r <= 1'b1;
         end
         if (gate_on)
         begin
            if (!tx_state_r[0] & baud_tick)
            begin
               tx_baud_r <= (tx_baud_r >= cnt_r - 8'h01) ? 8'h00 : tx_baud_r + 8'h01;
            end
            case (tx_state_r)
               TX_IDLE:
               begin
                  tx_baud_r <= 8'h00;
                  o_tx <= 1'b1;
                  if (txbuf_full_r & ctr_r[`SERIAL_CONTROL_TX_EN] & ~data_wr)
                  begin
                     tx_sh_r <= txbuf_r;
                     txbuf_full_r <= 1'b0;
                     tx_state_r <= TX_START;
                     o_tx <= 1'b0;
                  end
               end
               TX_START:
               begin
                  if (baud_tick & (tx_baud_r >= cnt_r - 8'h01))
                  begin
                     o_tx <= tx_sh_r[0];
                     tx_bit_r <= 3'h0;
                     tx_state_r <= TX_DATA;
                  end
               end
               TX_DATA:
               begin
                  if (baud_tick & (tx_baud_r >= cnt_r - 8'h01))
                  begin
                     tx_sh_r <= {1'b0, tx_sh_r[7:1]};
                     if (tx_bit_r == 3'h7)
                     begin
                        o_tx <= 1'b1;
                        tx_stop_r <= ctr_r[5:4];
                        tx_state_r <= TX_STOP;
                     end
                     else
                     begin
                        o_tx <= tx_sh_r[1];
                        tx_bit_r <= tx_bit_r + 3'h1;
                     end
                  end
               end
               TX_STOP:
               begin
                  if (baud_tick & (tx_baud_r >= cnt_r - 8'h01))
                  begin
                     if (tx_stop_r == 2'h0)
                     begin
                        tx_state_r <= TX_IDLE;
                     end
                     else
                     begin
                        tx_stop_r <= tx_stop_r - 2'h1;
                     end
                  end
               end
               default: tx_state_r <= TX_IDLE;
            endcase
         end
      end
   end

   // Receiver: samples at mid-bit of counter period
   wire rx_half = baud_tick & (rx_baud_r == {1'b0, cnt_r[7:1]});
   wire rx_wrap = baud_tick & (rx_baud_r >= cnt_r - 8'h01);
   // Any low stop bit ends the character, first of two included
   assign rx_done = rx_state_r[3] & rx_half & (~rx_stop_r | rx_fer);
   assign rx_fer = ~i_rx;
   assign pass_byte = sta_r[`SERIAL_STATUS_FLAGS_NOPRE] | ~filt_armed_r | (filt_seen_r == 2'h3);

   always @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         rx_state_r <= RX_IDLE;
         rx_baud_r <= 8'h00;
         rx_sh_r <= 8'h00;
         rx_bit_r <= 3'h0;
         rx_stop_r <= 1'b0;
         filt_armed_r <= 1'b0;
         filt_seen_r <= 2'h0;
         rx_push_r <= 1'b0;
      end
      else
      begin
         rx_push_r <= 1'b0;
         if (i_wr & ctr_sel & i_wdata[`SERIAL_CONTROL_REARM])
         begin
            filt_armed_r <= 1'b1;
            filt_seen_r <= 2'h0;
         end
         if (gate_on)
         begin
            if (!rx_state_r[0] & baud_tick)
            begin
               rx_baud_r <= rx_wrap ? 8'h00 : rx_baud_r + 8'h01;
            end
            case (rx_state_r)
               RX_IDLE:
               begin
                  rx_baud_r <= 8'h00;
                  if (~i_rx & ctr_r[`SERIAL_CONTROL_RX_EN])
                  begin
                     rx_state_r <= RX_START;
                  end
               end
               RX_START:
               begin
                  if (rx_half)
                  begin
                     rx_state_r <= i_rx ? RX_IDLE : RX_DATA;
                     rx_bit_r <= 3'h0;
                  end
               end
               RX_DATA:
               begin
                  if (rx_half)
                  begin
                     rx_sh_r <= {i_rx, rx_sh_r[7:1]};
                     if (rx_bit_r == 3'h7)
                     begin
                        rx_stop_r <= ctr_r[`SERIAL_CONTROL_RX_STOP];
                        rx_state_r <= RX_STOP;
                     end
                     rx_bit_r <= rx_bit_r + 3'h1;
                  end
               end
               RX_STOP:
               begin
                  if (rx_half)
                  begin
                     if (rx_fer)
                     begin
                        rx_state_r <= RX_IDLE;
                     end
                     else if (rx_stop_r)
                     begin
                        rx_stop_r <= 1'b0;
                     end
                     else
                     begin
                        rx_state_r <= RX_IDLE;
                        if (pass_byte)
                        begin
                           rx_push_r <= fifo_in_ready;
                        end
                        else if (filt_seen_r == 2'h2)
                        begin
                           filt_seen_r <= (rx_sh_r == 8'hFF) ? 2'h3 :
                                          2'h2 & {2{rx_sh_r == 8'h00}};
                        end
                        else
                        begin
                           filt_seen_r <= (rx_sh_r == 8'h00) ? filt_seen_r + 2'h1 : 2'h0;
                        end
                     end
                  end
               end
               default: rx_state_r <= RX_IDLE;
            endcase
         end
      end
   end

   // Holding FIFO between shift register and FIFO manager
   hsu_fifo #(
      .WIDTH(`HSU_FIFO_WIDTH),
      .DEPTH(`HSU_FIFO_DEPTH),
      .AW(`HSU_FIFO_AW)
   ) u_rx_fifo (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_flush(1'b0),
      .i_in_data(rx_sh_r),
      .i_in_valid(rx_push_r),
      .o_in_ready(fifo_in_ready),
      .o_out_data(fifo_out_data),
      .o_out_valid(fifo_out_valid),
      .i_out_ready(fifo_pop)
   );

   assign fifo_pop = fifo_out_valid & (~o_fifo_valid | i_fifo_accept);

   always @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_fifo_valid <= 1'b0;
         o_fifo_data <= 8'h00;
         rx_byte_r <= 8'h00;
         rx_prev_r <= 1'b1;
         wake_cnt_r <= 3'h0;
         o_wake_request <= 1'b0;
      end
      else
      begin
         if (fifo_pop)
         begin
            o_fifo_valid <= 1'b1;
            o_fifo_data <= fifo_out_data;
            rx_byte_r <= fifo_out_data;
         end
         else if (i_fifo_accept)
         begin
            o_fifo_valid <= 1'b0;
         end
         rx_prev_r <= i_rx;
         if (i_wr & ctr_sel & i_wdata[`SERIAL_CONTROL_WAKE_ARM])
         begin
            wake_cnt_r <= 3'h0;
         end
         else if (i_rx & ~rx_prev_r & (wake_cnt_r != `HSU_WAKE_COUNT))
         begin
            wake_cnt_r <= wake_cnt_r + 3'h1;
         end
         o_wake_request <= (wake_cnt_r == `HSU_WAKE_COUNT);
      end
   end
endmodule

// >>> test/hsu_uart_sva.sv
// Assertions on the host serial port, seen from its pins only.
// Assumes hsu_map.vh on the include path and one clock domain.
`timescale 1ns/1ps
`include "hsu_map.vh"
module hsu_uart_sva
(
   input wire i_clk,
   input wire i_nrst,
   input wire [7:0] i_addr,
   input wire i_wr,
   input wire i_rd,
   input wire [7:0] i_wdata,
   input wire [7:0] o_rdata,
   input wire i_cpu_irq_gate,
   input wire i_rx,
   input wire o_tx,
   input wire o_fifo_valid,
   input wire [7:0] o_fifo_data,
   input wire i_fifo_accept,
   input wire o_wake_request,
   input wire o_irq
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   wire sta_wr = i_wr && i_addr == `HSU_ADDR_STA;
   wire sta_rd = i_rd && i_addr == `HSU_ADDR_STA;
   wire wake_clr = i_wr && i_addr == `HSU_ADDR_CTR && i_wdata[`SERIAL_CONTROL_WAKE_ARM];
   wire mapped = i_addr == `HSU_ADDR_STA || i_addr == `HSU_ADDR_CTR ||
      i_addr == `HSU_ADDR_PRE || i_addr == `HSU_ADDR_CNT || i_addr == `HSU_ADDR_FIFO_DATA_PORT;
   reg rx_q;
   reg [3:0] since_rise_r;
   // Cycles since the last rising edge on the receive line, saturating
   always @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         rx_q <= 1'b1;
         since_rise_r <= 4'hF;
      end
      else
      begin
         rx_q <= i_rx;
         if (i_rx && !rx_q)
            since_rise_r <= 4'h0;
         else if (since_rise_r != 4'hF)
            since_rise_r <= since_rise_r + 4'h1;
      end
   end
   a_irq_needs_gate: assert property (!$past(i_cpu_irq_gate) |-> !o_irq)
      else $error("irq raised with gate closed");
   a_rdata_holds: assert property (!$past(i_rd) |-> $stable(o_rdata))
      else $error("read data changed without a read");
   a_unmapped_zero: assert property ($past(i_rd && !mapped) |-> o_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_reserved_reads_zero: assert property ($past(sta_rd) |-> o_rdata[6:5] == 2'b00)
      else $error("reserved status bits not zero");
   a_sta_write_set: assert property ($past(sta_wr && i_wdata[7], 3) && $past(sta_rd) |->
      (o_rdata[4:2] & $past(i_wdata[4:2], 3)) == $past(i_wdata[4:2], 3))
      else $error("status set write lost");
   a_sta_write_clear: assert property ($past(sta_wr && !i_wdata[7], 3) && $past(sta_rd) |->
      (o_rdata[4:2] & $past(i_wdata[4:2], 3)) == 3'b000)
      else $error("status clear write lost");
   a_fifo_offer_holds: assert property (o_fifo_valid && !i_fifo_accept |=>
      o_fifo_valid && $stable(o_fifo_data))
      else $error("offered byte withdrawn");
   a_wake_after_edge: assert property ($rose(o_wake_request) |-> since_rise_r <= 4'h4)
      else $error("wake without receive edge");
   a_wake_clear_cause: assert property ($fell(o_wake_request) |->
      $past(wake_clr) || $past(wake_clr, 2))
      else $error("wake dropped without clear");
   c_forward: cover property (o_fifo_valid && i_fifo_accept);
   c_irq: cover property ($rose(o_irq));
   c_wake: cover property ($rose(o_wake_request));
endmodule

bind hsu_uart hsu_uart_sva i_hsu_uart_sva (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr),
   .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata),
   .i_cpu_irq_gate(i_cpu_irq_gate), .i_rx(i_rx), .o_tx(o_tx), .o_fifo_valid(o_fifo_valid),
   .o_fifo_data(o_fifo_data), .i_fifo_accept(i_fifo_accept),
   .o_wake_request(o_wake_request), .o_irq(o_irq));

// >>> test/hsu_host_model.sv
// Host side of the serial link: sends characters, captures transmitted ones.
// Assumes the receive line must change just after a rising edge of i_clk.
`timescale 1ns/1ps
module hsu_host_model #(
   parameter real BIT_NS = 147.5
)
(
   input wire i_clk,
   input wire i_tx,
   output logic o_rx
);
   logic [7:0] got_q[$];
   realtime start_t[$];
   realtime t0;
   initial o_rx = 1'b1;
   // Absolute bit schedule so clock alignment never accumulates drift
   task automatic put(input logic v, input int j);
      #(t0 + j * BIT_NS - $realtime);
      @(posedge i_clk);
      #1 o_rx = v;
   endtask
   task automatic send(input logic [7:0] d, input logic [1:0] s);
      t0 = $realtime;
      put(1'b0, 0);
      for (int i = 0; i < 8; i++)
         put(d[i], i + 1);
      put(s[0], 9);
      put(s[1], 10);
      put(1'b1, 11);
   endtask
   task automatic pulse;
      t0 = $realtime;
      put(1'b0, 0);
      put(1'b1, 1);
      put(1'b1, 2);
   endtask
   always @(negedge i_tx)
   begin : capture
      logic [7:0] d;
      start_t.push_back($realtime);
      #(BIT_NS * 1.5);
      for (int i = 0; i < 8; i++)
      begin
         d[i] = i_tx;
         #(BIT_NS);
      end
      got_q.push_back(d);
   end
endmodule

// >>> test/hsu_uart_tb.sv
// Self-checking bench for the host serial port.
// Assumes hsu_map.vh on the include path; baud set to divider 4, prescale 0.
`timescale 1ns/1ps
`include "hsu_map.vh"
module hsu_uart_tb;
   localparam real BIT_NS = 4 * 1000.0 / 27.12;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] addr = 8'h00;
   logic wr_s = 1'b0;
   logic rd = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic gate = 1'b0;
   logic accept = 1'b1;
   wire rx, tx, fvalid, wake, irq;
   wire [7:0] rdata, fifo_data_port;
   int n_errors = 0;
   int samples_checked = 0;
   logic [7:0] fwd_q[$];
   logic [7:0] ra[5] = '{`HSU_ADDR_STA, `HSU_ADDR_CTR, `HSU_ADDR_PRE, `HSU_ADDR_CNT, 8'h50};
   logic [7:0] re[5] = '{`SERIAL_STATUS_FLAGS_RESET, `SERIAL_CONTROL_RESET, `HSU_PRE_RESET, `BAUD_DIVIDER_COUNT_RESET, 8'h00};
   always #4 clk = ~clk;
   hsu_uart i_hsu_uart (.i_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wr(wr_s), .i_rd(rd),
      .i_wdata(wdata), .o_rdata(rdata), .i_cpu_irq_gate(gate), .i_rx(rx), .o_tx(tx),
      .o_fifo_valid(fvalid), .o_fifo_data(fifo_data_port), .i_fifo_accept(accept),
      .o_wake_request(wake), .o_irq(irq));
   hsu_host_model #(.BIT_NS(BIT_NS)) i_hsu_host_model (.i_clk(clk), .i_tx(tx), .o_rx(rx));
   always @(posedge clk)
      if (fvalid && accept)
         fwd_q.push_back(fifo_data_port);
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr_s = 1'b1;
      cyc(1);
      wr_s = 1'b0;
      // Idle edge so a following write never retoggles the strobe at once
      cyc(1);
   endtask
   task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
      addr = a;
      rd = 1'b1;
      cyc(1);
      rd = 1'b0;
      cyc(1);
      chk(n, rdata, e);
   endtask
   // Bounded wait on the forwarded queue (0) or the host capture queue (1)
   task automatic wait_n(input bit which, input int n);
      int k;
      for (k = 0; k < 20000; k++)
      begin
         if ((which ? i_hsu_host_model.got_q.size() : fwd_q.size()) >= n)
            break;
         cyc(1);
      end
      if (k == 20000)
      begin
         n_errors++;
         wrap_up();
      end
   endtask
   task automatic frame(input logic [7:0] b[$], input logic [7:0] e[$]);
      fwd_q.delete();
      foreach (b[i])
         i_hsu_host_model.send(b[i], 2'b11);
      wait_n(0, e.size());
      cyc(60);
      chk("fwd_count", 8'(fwd_q.size()), 8'(e.size()));
      foreach (e[i])
         chk("fwd_byte", fwd_q[i], e[i]);
   endtask
   // Bad stop bit: flag and its interrupt, then clear; idle lets the character finish
   task automatic bad(input logic [7:0] d, input logic [1:0] p);
      i_hsu_host_model.send(d, p);
      cyc(300);
      rchk("sta_fer", `HSU_ADDR_STA, 8'h0D);
      chk("irq_fer", {7'h00, irq}, 8'h01);
      wr(`HSU_ADDR_STA, 8'h01);
      cyc(2);
      chk("irq_clr", {7'h00, irq}, 8'h00);
   endtask
   initial
   begin
      repeat (8) @(posedge clk);
      #1 nrst = 1'b1;
      for (int i = 0; i < 5; i++)
         rchk("reset_val", ra[i], re[i]);
      wr(`HSU_ADDR_STA, 8'hFF);
      rchk("sta_set", `HSU_ADDR_STA, 8'h1F);
      wr(`HSU_ADDR_STA, 8'h7F);
      rchk("sta_clr", `HSU_ADDR_STA, 8'h00);
      wr(`HSU_ADDR_PRE, 8'h00);
      wr(`HSU_ADDR_CNT, 8'h04);
      rchk("cnt_rw", `HSU_ADDR_CNT, 8'h04);
      wr(`HSU_ADDR_CTR, 8'h07);
      frame('{8'h00, 8'h00, 8'hFF, 8'hA5}, '{8'h00, 8'h00, 8'hFF, 8'hA5});
      wr(`HSU_ADDR_CTR, 8'h47);
      frame('{8'h11, 8'h00, 8'h00, 8'hFF, 8'h3C}, '{8'h3C});
      wr(`HSU_ADDR_STA, 8'h90);
      wr(`HSU_ADDR_CTR, 8'h47);
      frame('{8'h00, 8'h00, 8'hFF}, '{8'h00, 8'h00, 8'hFF});
      wr(`HSU_ADDR_STA, 8'h10);
      wr(`HSU_ADDR_STA, 8'h8C);
      gate = 1'b1;
      bad(8'h55, 2'b00);
      wr(`HSU_ADDR_CTR, 8'h0F);
      frame('{8'h00, 8'h00, 8'hFF, 8'h66}, '{8'h66});
      bad(8'h77, 2'b01);
      bad(8'h33, 2'b10);
      wr(`HSU_ADDR_CTR, 8'h07);
      accept = 1'b0;
      fwd_q.delete();
      // Output register holds one byte, so 33 fill the path
      for (int i = 0; i < 33; i++)
         i_hsu_host_model.send(8'h40 + 8'(i), 2'b11);
      cyc(60);
      rchk("sta_full", `HSU_ADDR_STA, 8'h0C);
      i_hsu_host_model.send(8'hEE, 2'b11);
      cyc(60);
      rchk("sta_ovr", `HSU_ADDR_STA, 8'h0E);
      chk("irq_ovr", {7'h00, irq}, 8'h01);
      wr(`HSU_ADDR_STA, 8'h08);
      cyc(2);
      chk("irq_mask", {7'h00, irq}, 8'h00);
      accept = 1'b1;
      wait_n(0, 33);
      cyc(60);
      chk("drain_count", 8'(fwd_q.size()), 8'h21);
      chk("drain_first", fwd_q[0], 8'h40);
      chk("drain_last", fwd_q[32], 8'h60);
      rchk("rx_port", `HSU_ADDR_FIFO_DATA_PORT, 8'h60);
      // Two loads per stop setting; start-to-start spacing gives the stop count
      for (int k = 0; k < 4; k++)
      begin
         cyc(120);
         wr(`HSU_ADDR_CTR, 8'h07 | 8'(k << 4));
         i_hsu_host_model.got_q.delete();
         i_hsu_host_model.start_t.delete();
         wr(`HSU_ADDR_FIFO_DATA_PORT, 8'hA5 ^ 8'(k));
         cyc(4);
         wr(`HSU_ADDR_FIFO_DATA_PORT, 8'h5A);
         wait_n(1, 2);
         chk("tx_first", i_hsu_host_model.got_q[0], 8'hA5 ^ 8'(k));
         chk("tx_second", i_hsu_host_model.got_q[1], 8'h5A);
         chk("tx_bits", 8'($rtoi((i_hsu_host_model.start_t[1] -
            i_hsu_host_model.start_t[0]) / BIT_NS + 0.5)), 8'(10 + k));
      end
      cyc(120);
      i_hsu_host_model.got_q.delete();
      wr(`HSU_ADDR_CTR, 8'h06);
      wr(`HSU_ADDR_FIFO_DATA_PORT, 8'hC3);
      cyc(200);
      chk("gate_off", 8'(i_hsu_host_model.got_q.size()), 8'h00);
      wr(`HSU_ADDR_CTR, 8'h07);
      wait_n(1, 1);
      chk("gate_on", i_hsu_host_model.got_q[0], 8'hC3);
      cyc(120);
      wr(`HSU_ADDR_CTR, 8'h85);
      cyc(3);
      chk("wake_armed", {7'h00, wake}, 8'h00);
      repeat (4) i_hsu_host_model.pulse();
      cyc(10);
      chk("wake_four", {7'h00, wake}, 8'h00);
      i_hsu_host_model.pulse();
      cyc(10);
      chk("wake_five", {7'h00, wake}, 8'h01);
      wr(`HSU_ADDR_CTR, 8'h85);
      cyc(3);
      chk("wake_clear", {7'h00, wake}, 8'h00);
      wrap_up();
   end
endmodule
